/* File: design/clcu_top.sv */
// Purpose: control link command unit of a packet routing switch
// Assumes: config registers answer on cfg_ack within the ref_clk domain
// Notes: received link clock and data are sampled, not used as a clock
`timescale 1ns/1ps
`default_nettype none
`include "clcu_consts.svh"
module clcu_top import clcu_pkg::*; #(
  parameter logic [7:0] TX_HALF = 8'(`CLCU_HALF_CYC)
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        pri_rx_clk,
  input  wire logic        pri_rx_data,
  output logic             pri_tx_clk,
  output logic             pri_tx_data,
  input  wire logic        chain_active,
  output logic             chain_tx_clk,
  output logic             chain_tx_data,
  input  wire logic [15:0] device_type,
  output logic             cfg_rd_req,
  output logic             cfg_wr_req,
  output logic [15:0]      cfg_addr,
  output logic [31:0]      cfg_wdata,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_ack,
  input  wire logic        cfg_bad_addr,
  input  wire logic        link_err,
  input  wire logic [7:0]  link_err_code,
  input  wire logic [7:0]  link_err_num,
  output logic             reset_req,
  output logic [7:0]       reset_level
);
  typedef struct packed {
    logic            lc1, lc2, lc3, ld1, ld2, ca1, ca2;
    logic            rx_busy;
    logic [3:0]      rx_cnt;
    logic [8:0]      rx_sh;
    logic            rx_vld;
    clcu_parse_type  pst;
    logic [7:0]      hdr0;
    logic            labelled;
    logic            started;
    logic [15:0]     label;
    logic [15:0]     rhdr;
    logic [6:0][7:0] body;
    logic [3:0]      blen;
    logic [7:0]      cmd;
    clcu_msg_type    mst;
    logic [13:0][8:0] msg;
    logic [3:0]      mlen;
    logic [3:0]      midx;
    logic            cut;
    logic            is_err;
    logic            pvld;
    logic            err_pend;
    logic [7:0]      err_code;
    logic [7:0]      err_link;
    logic            cvld;
    logic [8:0]      ctok;
    logic            hv;
    logic [8:0]      hold;
    logic            cfg_rd;
    logic            cfg_wr;
    logic [15:0]     cfg_a;
    logic [31:0]     cfg_w;
    logic [31:0]     cfg_res;
    logic            cfg_bad;
    logic            rst_pulse;
    logic [7:0]      rst_lvl;
  } clcu_state_type;

  clcu_state_type st;
  clcu_state_type nxt_st;
  clcu_tok_if     pri_if ();
  clcu_tok_if     chn_if ();

  logic        r_ctl;
  logic [7:0]  r_byte;
  logic        r_end;
  logic        ours;
  logic        cmd_end;
  logic        preempt;
  logic [15:0] new_hdr;

  // received token appears one cycle after its last bit
  assign r_ctl   = st.rx_sh[0];
  assign r_byte  = st.rx_sh[8:1];
  assign r_end   = st.rx_vld && r_ctl &&
                   (r_byte == `CLCU_TOK_EOP || r_byte == `CLCU_TOK_EOM);
  assign ours    = !st.labelled || {st.hdr0, r_byte} == st.label; // RQ2
  assign cmd_end = st.pst == P_BODY && r_end;
  // reset and recovery may overtake a reply still in flight
  assign preempt = st.body[0] == `CLCU_CMD_RESET ||
                   st.body[0] == `CLCU_CMD_RECOVER; // RQ9 RQ18
  assign new_hdr = {st.body[2], st.body[1]}; // RQ14

  assign pri_if.vld = st.pvld;
  assign pri_if.tok = st.msg[st.midx];
  assign chn_if.vld = st.cvld;
  assign chn_if.tok = st.ctok;
  assign cfg_rd_req  = st.cfg_rd;
  assign cfg_wr_req  = st.cfg_wr;
  assign cfg_addr    = st.cfg_a;
  assign cfg_wdata   = st.cfg_w;
  assign reset_req   = st.rst_pulse;
  assign reset_level = st.rst_lvl;

  always_comb begin
    logic [3:0] k;
    k = 4'h0;
    nxt_st = st;
    nxt_st.rx_vld    = 1'b0;
    nxt_st.rst_pulse = 1'b0;
    nxt_st.cfg_rd    = 1'b0;
    nxt_st.cfg_wr    = 1'b0;
    nxt_st.lc1 = pri_rx_clk;
    nxt_st.lc2 = st.lc1;
    nxt_st.lc3 = st.lc2;
    nxt_st.ld1 = pri_rx_data;
    nxt_st.ld2 = st.ld1;
    nxt_st.ca1 = chain_active;
    nxt_st.ca2 = st.ca1;
    // sample data on each rising link clock edge
    if (st.lc2 && !st.lc3) begin
      if (!st.rx_busy) begin
        if (st.ld2) begin
          nxt_st.rx_busy = 1'b1;
          nxt_st.rx_cnt  = 4'h0;
        end
      end else begin
        nxt_st.rx_sh = {st.ld2, st.rx_sh[8:1]};
        if (st.rx_cnt == `CLCU_RX_LAST) begin
          nxt_st.rx_busy = 1'b0;
          nxt_st.rx_vld  = 1'b1;
        end else begin
          nxt_st.rx_cnt = st.rx_cnt + 4'h1;
        end
      end
    end
    // chain side: one token in flight plus one held
    if (st.cvld && chn_if.rdy) nxt_st.cvld = 1'b0;
    if (!nxt_st.cvld && st.hv) begin
      nxt_st.cvld = 1'b1;
      nxt_st.ctok = st.hold;
      nxt_st.hv   = 1'b0;
    end
    // primary side: stream the composed message
    if (st.mst == M_SEND && st.pvld && pri_if.rdy) begin // RQ1
      if (st.midx == st.mlen - 4'h1) begin
        nxt_st.pvld = 1'b0;
        nxt_st.mst  = M_IDLE;
      end else begin
        nxt_st.midx = st.midx + 4'h1;
      end
    end
    if (st.mst == M_CFG && cfg_ack) begin
      nxt_st.cfg_res = cfg_rdata;
      nxt_st.cfg_bad = cfg_bad_addr;
      nxt_st.mst     = M_BUILD;
    end
    // pending error goes out only once a start reply has gone
    if (st.mst == M_IDLE && st.err_pend && st.started && !st.rx_vld) begin
      nxt_st.msg[0] = {1'b0, st.rhdr[7:0]}; // RQ5
      nxt_st.msg[1] = {1'b0, st.rhdr[15:8]};
      nxt_st.msg[2] = {1'b0, st.err_code}; // RQ23
      nxt_st.msg[3] = {1'b0, st.err_link};
      nxt_st.msg[4] = {1'b1, `CLCU_TOK_EOM};
      nxt_st.mlen     = 4'h5;
      nxt_st.midx     = 4'h0;
      nxt_st.pvld     = 1'b1;
      nxt_st.is_err   = 1'b1;
      nxt_st.mst      = M_SEND;
      nxt_st.err_pend = 1'b0; // RQ16 RQ20
    end
    if (st.mst == M_BUILD) begin
      if (st.cut) begin
        nxt_st.msg[k] = {1'b1, `CLCU_TOK_EOM}; // RQ18
        k = k + 4'h1;
      end
      nxt_st.msg[k] = {1'b0, st.rhdr[7:0]}; // RQ15
      nxt_st.msg[k + 4'h1] = {1'b0, st.rhdr[15:8]};
      nxt_st.msg[k + 4'h2] = {1'b1, `CLCU_TOK_EOP}; // RQ7
      k = k + 4'h3;
      if (st.cmd == `CLCU_CMD_START && st.blen == `CLCU_LEN_START) begin
        nxt_st.rhdr    = new_hdr; // RQ14
        nxt_st.started = 1'b1;
      end
      nxt_st.msg[k] = {1'b0, nxt_st.rhdr[7:0]}; // RQ10 RQ15
      nxt_st.msg[k + 4'h1] = {1'b0, nxt_st.rhdr[15:8]};
      nxt_st.msg[k + 4'h2] = {1'b0, st.cmd ^ `CLCU_RESP_FLIP}; // RQ11
      k = k + 4'h3;
      nxt_st.msg[k] = {1'b0, `CLCU_ST_FAIL}; // RQ25
      unique case (st.cmd)
        `CLCU_CMD_START: begin
          if (st.blen == `CLCU_LEN_START) nxt_st.msg[k] = 9'h000; // RQ12
        end
        `CLCU_CMD_RESET: begin
          if (st.blen == `CLCU_LEN_RESET &&
              st.body[1] <= `CLCU_RST_LVL_MAX) begin
            nxt_st.msg[k]    = {1'b0, `CLCU_ST_OK}; // RQ17
            nxt_st.rst_pulse = 1'b1;
            nxt_st.rst_lvl   = st.body[1];
          end
        end
        `CLCU_CMD_IDENT: begin
          nxt_st.msg[k] = {1'b0, device_type[7:0]}; // RQ19
          nxt_st.msg[k + 4'h1] = {1'b0, device_type[15:8]};
          nxt_st.msg[k + 4'h2] = 9'h000;
          nxt_st.msg[k + 4'h3] = 9'h000;
          k = k + 4'h3;
        end
        `CLCU_CMD_RECOVER, `CLCU_CMD_ERRACK: begin
          nxt_st.msg[k] = {1'b0, `CLCU_ST_OK}; // RQ20
        end
        `CLCU_CMD_PEEK: begin
          if (!st.cfg_bad) nxt_st.msg[k] = {1'b0, `CLCU_ST_OK}; // RQ21
          nxt_st.msg[k + 4'h1] = {1'b0, st.cfg_res[7:0]};
          nxt_st.msg[k + 4'h2] = {1'b0, st.cfg_res[15:8]};
          nxt_st.msg[k + 4'h3] = {1'b0, st.cfg_res[23:16]};
          nxt_st.msg[k + 4'h4] = {1'b0, st.cfg_res[31:24]};
          k = k + 4'h4;
        end
        `CLCU_CMD_POKE: begin
          if (!st.cfg_bad) nxt_st.msg[k] = {1'b0, `CLCU_ST_OK}; // RQ22
        end
        default: ;
      endcase
      nxt_st.msg[k + 4'h1] = {1'b1, `CLCU_TOK_EOM}; // RQ10
      nxt_st.mlen   = k + 4'h2;
      nxt_st.midx   = 4'h0;
      nxt_st.pvld   = 1'b1;
      nxt_st.is_err = 1'b0;
      nxt_st.mst    = M_SEND;
    end
    if (st.rx_vld) begin
      unique case (st.pst)
        P_HDR0: begin
          if (!r_ctl) begin
            nxt_st.hdr0 = r_byte;
            nxt_st.pst  = P_HDR1;
          end
        end
        P_HDR1: begin
          if (r_ctl) begin
            nxt_st.pst = P_HDR0;
          end else if (ours) begin
            nxt_st.labelled = 1'b1; // RQ2
            nxt_st.label    = {st.hdr0, r_byte};
            nxt_st.blen     = 4'h0;
            nxt_st.pst      = P_BODY;
          end else if (st.ca2) begin
            nxt_st.cvld = 1'b1; // RQ3
            nxt_st.ctok = {1'b0, st.hdr0};
            nxt_st.hold = {1'b0, r_byte};
            nxt_st.hv   = 1'b1;
            nxt_st.pst  = P_FWD;
          end else begin
            nxt_st.err_pend = 1'b1; // RQ3
            nxt_st.err_code = `CLCU_ERR_PROTO;
            nxt_st.err_link = `CLCU_CTRL_LINK;
            nxt_st.pst      = P_DROP;
          end
        end
        P_BODY: begin
          if (!r_ctl && st.blen != `CLCU_BODY_MAX) begin
            nxt_st.body[st.blen[2:0]] = r_byte; // RQ6
            nxt_st.blen = st.blen + 4'h1;
          end
          if (r_end) nxt_st.pst = P_HDR0;
        end
        P_FWD: begin
          // a held token is overwritten if the chain link stalls too long
          if (!nxt_st.cvld) begin
            nxt_st.cvld = 1'b1;
            nxt_st.ctok = st.rx_sh[0] ? {1'b1, r_byte} : {1'b0, r_byte};
          end else begin
            nxt_st.hold = {r_ctl, r_byte};
            nxt_st.hv   = 1'b1;
          end
          if (r_end) nxt_st.pst = P_HDR0;
        end
        P_DROP: begin
          if (r_end) nxt_st.pst = P_HDR0;
        end
        default: nxt_st.pst = P_HDR0;
      endcase
    end
    if (cmd_end) begin
      if (st.blen == 4'h0) begin
        nxt_st.err_pend = 1'b1; // RQ6
        nxt_st.err_code = `CLCU_ERR_PROTO;
        nxt_st.err_link = `CLCU_CTRL_LINK;
      end else if (st.mst == M_IDLE || preempt) begin
        nxt_st.cmd  = st.body[0];
        nxt_st.cut  = st.mst == M_SEND && st.midx != 4'h0; // RQ18
        nxt_st.pvld = 1'b0;
        nxt_st.cfg_bad = 1'b1;
        nxt_st.mst  = M_BUILD;
        nxt_st.cfg_a = {st.body[2], st.body[1]};
        nxt_st.cfg_w = {st.body[6], st.body[5], st.body[4], st.body[3]};
        if (st.body[0] == `CLCU_CMD_PEEK && st.blen == `CLCU_LEN_PEEK) begin
          nxt_st.cfg_rd = 1'b1; // RQ21
          nxt_st.mst    = M_CFG;
        end
        if (st.body[0] == `CLCU_CMD_POKE && st.blen == `CLCU_LEN_POKE) begin
          nxt_st.cfg_wr = 1'b1; // RQ22
          nxt_st.mst    = M_CFG;
        end
      end
    end
    // an outside link error raised now wins over a clear
    if (link_err) begin
      nxt_st.err_pend = 1'b1;
      nxt_st.err_code = link_err_code;
      nxt_st.err_link = link_err_num;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) st <= '0;
    else if (ce) st <= nxt_st;
  end

  clcu_tx #(.HALF(TX_HALF)) u_pri_tx (
    .ref_clk (ref_clk),
    .srst    (srst),
    .ce      (ce),
    .snk     (pri_if),
    .tx_clk  (pri_tx_clk),
    .tx_data (pri_tx_data)
  );
  clcu_tx #(.HALF(TX_HALF)) u_chn_tx (
    .ref_clk (ref_clk),
    .srst    (srst),
    .ce      (ce),
    .snk     (chn_if),
    .tx_clk  (chain_tx_clk),
    .tx_data (chain_tx_data)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst || !ce);
  logic first_reply;
  assign first_reply = st.mst == M_SEND && st.midx == 4'h0 &&
                       !st.is_err && !st.cut;

  a_resp_code_flip: assert property ( // RQ11
    first_reply |-> st.msg[5][7:0] == (st.cmd ^ `CLCU_RESP_FLIP))
    else $error("reply code not command with top bit inverted");
  a_ack_empty_eop: assert property ( // RQ7
    first_reply |-> st.msg[2] == {1'b1, `CLCU_TOK_EOP})
    else $error("acknowledge packet is not empty");
  a_reply_ends_eom: assert property ( // RQ10
    st.mst == M_SEND |-> st.msg[st.mlen - 4'h1] == {1'b1, `CLCU_TOK_EOM})
    else $error("message not closed by end-of-message");
  a_ack_old_hdr: assert property ( // RQ15
    first_reply && $past(st.mst) == M_BUILD |->
      st.msg[0][7:0] == $past(st.rhdr[7:0]) &&
      st.msg[3][7:0] == st.rhdr[7:0])
    else $error("acknowledge or reply header wrong");
  a_label_learn: assert property ( // RQ2
    $rose(st.labelled) |-> st.pst == P_BODY && $past(st.pst) == P_HDR1)
    else $error("label taken outside a header");
  a_fwd_chain: assert property ( // RQ3
    st.pst == P_HDR1 && st.rx_vld && !r_ctl && !ours && st.ca2 |=>
      st.cvld && st.ctok == {1'b0, $past(st.hdr0)} && st.pst == P_FWD)
    else $error("foreign packet not forwarded");
  a_drop_err: assert property ( // RQ3
    st.pst == P_HDR1 && st.rx_vld && !r_ctl && !ours && !st.ca2 |=>
      st.err_pend && st.pst == P_DROP)
    else $error("dropped packet raised no error");
  a_err_after_start: assert property ( // RQ16
    st.mst == M_SEND && st.is_err |-> st.started)
    else $error("error message before start reply");
  a_ident_upper: assert property ( // RQ19
    first_reply && st.cmd == `CLCU_CMD_IDENT |->
      st.msg[8] == 9'h000 && st.msg[9] == 9'h000)
    else $error("identify upper half not zero");
  a_cfg_answer: assert property ( // RQ21
    cfg_rd_req |-> st.mst == M_CFG ##1 st.mst != M_IDLE)
    else $error("config read without wait");

  c_forward: cover property (st.pst == P_FWD && r_end);
  c_error_sent: cover property (st.mst == M_SEND && st.is_err);
  c_peek_reply: cover property (first_reply && st.cmd == `CLCU_CMD_PEEK);
  c_cut_reply: cover property (st.mst == M_BUILD && st.cut);
endmodule
`default_nettype wire

/* File: design/clcu_consts.svh */
// Purpose: constants of the control link command unit
// Assumes: 50 MHz ref_clk, tokens of flag bit plus one byte
// Notes on behaviour
// RQ1 - commands arrive and all answers leave on the primary control link only
// RQ2 - first command header after power-up becomes the unit's own label
// RQ3 - foreign header: forward on chain link if active, else drop and error
// RQ4 - controller sends start as the very first command
// RQ5 - every output toward the controller begins with the return header
// RQ6 - command packet: header, one command code byte, optional parameter bytes
// RQ7 - each command packet gets an empty packet closed by end-of-packet
// RQ8 - controller waits for each reply, except reset and error recovery
// RQ9 - error recovery accepted while the previous acknowledge is outstanding
// RQ10 - reply framed by return header and closed by end-of-message
// RQ11 - reply code is command code with its top bit inverted
// RQ12 - status byte zero on success, one on invalid or failed command
// RQ13 - command headers are two bytes; through-routing switches configured so
// RQ14 - start sets two-byte return header, first byte after code is byte zero
// RQ15 - start acknowledge uses old header, its reply uses the new one
// RQ16 - error before start: start reply goes out before the error message
// RQ17 - reset carries a level byte; valid level gives reply with status zero
// RQ18 - reset may cut a pending reply short with end-of-message
// RQ19 - identify returns 32 bits: device type low half, upper half zero
// RQ20 - error recovery reply precedes any unhandled error message
// RQ21 - config read: two-byte address, value in reply, failure if unmapped
// RQ22 - config write: two-byte address, four data bytes, failure if unmapped
// RQ23 - error message: error code byte, then link number, zero for control
// RQ24 - controller answers each error message with an error acknowledge
// RQ25 - unknown command code answered with failure status
`ifndef CLCU_CONSTS_SVH
`define CLCU_CONSTS_SVH
`define CLCU_CMD_START   8'h00
`define CLCU_CMD_RESET   8'h01
`define CLCU_CMD_IDENT   8'h02
`define CLCU_CMD_RECOVER 8'h03
`define CLCU_CMD_PEEK    8'h04
`define CLCU_CMD_POKE    8'h05
`define CLCU_CMD_ERRACK  8'h06
`define CLCU_RESP_FLIP   8'h80
`define CLCU_ST_OK       8'h00
`define CLCU_ST_FAIL     8'h01
`define CLCU_TOK_EOP     8'h01
`define CLCU_TOK_EOM     8'h02
`define CLCU_ERR_PROTO   8'h01
`define CLCU_CTRL_LINK   8'h00
`define CLCU_RST_LVL_MAX 8'h02
`define CLCU_LEN_START   4'h3
`define CLCU_LEN_RESET   4'h2
`define CLCU_LEN_PEEK    4'h3
`define CLCU_LEN_POKE    4'h7
`define CLCU_BODY_MAX    4'h7
`define CLCU_RX_LAST     4'h8
`define CLCU_TX_LAST     4'h9
`define CLCU_CLK_NS      20
`define CLCU_BIT_NS      120
`define CLCU_HALF_CYC    ((`CLCU_BIT_NS / 2) / `CLCU_CLK_NS)
`endif

/* File: design/clcu_pkg.sv */
// Purpose: types of the control link command unit
// Assumes: nothing
// Notes: token is {control flag, byte}
package clcu_pkg;
  typedef enum logic [2:0] {P_HDR0, P_HDR1, P_BODY, P_FWD, P_DROP}
    clcu_parse_type;
  typedef enum logic [1:0] {M_IDLE, M_CFG, M_BUILD, M_SEND} clcu_msg_type;
  typedef struct packed {
    logic [9:0] sh;
    logic [3:0] bits;
    logic       act;
    logic [8:0] hold;
    logic       hv;
    logic [7:0] div;
    logic       tclk;
    logic       tdat;
  } clcu_tx_type;
endpackage

/* File: design/clcu_tok_if.sv */
// Purpose: token handshake between command unit and transmitters
// Assumes: one clock domain
// Notes: tok[8] high marks a control token
`timescale 1ns/1ps
`default_nettype none
interface clcu_tok_if;
  logic       vld;
  logic       rdy;
  logic [8:0] tok;
  modport src (output vld, output tok, input rdy);
  modport snk (input vld, input tok, output rdy);
endinterface
`default_nettype wire

/* File: design/clcu_tx.sv */
// Purpose: serial token transmitter with its own strobed link clock
// Assumes: link clock stops between frames
// Notes: frame is start bit, flag, data lsb first
`timescale 1ns/1ps
`default_nettype none
`include "clcu_consts.svh"
module clcu_tx import clcu_pkg::*; #(
  parameter logic [7:0] HALF = 8'(`CLCU_HALF_CYC)
) (
  input  wire logic  ref_clk,
  input  wire logic  srst,
  input  wire logic  ce,
  clcu_tok_if.snk    snk,
  output logic       tx_clk,
  output logic       tx_data
);
  if (HALF == 8'h00) $error("clcu_tx: HALF must be nonzero");
  clcu_tx_type st;
  clcu_tx_type nxt_st;
  assign snk.rdy = !st.hv;
  assign tx_clk  = st.tclk;
  assign tx_data = st.tdat;
  always_comb begin
    nxt_st = st;
    if (snk.vld && !st.hv) begin
      nxt_st.hold = snk.tok;
      nxt_st.hv   = 1'b1;
    end
    if (!st.act) begin
      if (st.hv) begin
        nxt_st.sh   = {st.hold[7:0], st.hold[8], 1'b1};
        nxt_st.act  = 1'b1;
        nxt_st.bits = 4'h0;
        nxt_st.div  = 8'h00;
        nxt_st.hv   = 1'b0;
        nxt_st.tdat = 1'b1;
      end
    end else begin
      nxt_st.div = st.div + 8'h01;
      if (st.div == HALF - 8'h01) nxt_st.tclk = 1'b1;
      if (st.div == 8'((HALF << 1) - 8'h01)) begin
        nxt_st.tclk = 1'b0;
        nxt_st.div  = 8'h00;
        if (st.bits == `CLCU_TX_LAST) begin
          nxt_st.act  = 1'b0;
          nxt_st.tdat = 1'b0;
        end else begin
          nxt_st.bits = st.bits + 4'h1;
          nxt_st.sh   = {1'b0, st.sh[9:1]};
          nxt_st.tdat = st.sh[1];
        end
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) st <= '0;
    else if (ce) st <= nxt_st;
  end
  a_tx_clk_idle: assert property (@(posedge ref_clk) disable iff (srst) // RQ1
    !st.act |-> !st.tclk) else $error("link clock runs outside a frame");
endmodule
`default_nettype wire

/* File: tb/clcu_ctrl_model.sv */
// Purpose: controller side of the primary control link
// Assumes: link bit of 160 ns, link clock stands low between frames
// Notes: frame is start bit, flag, data lsb first; line idles at 0
`timescale 1ns/1ps
`default_nettype none
module clcu_tok_mon (
  input  wire logic rx_clk,
  input  wire logic rx_data
);
  logic [8:0] q[$];
  logic [8:0] sh;
  int         cnt = -1;
  // tokens land in q as {flag, byte}
  always @(posedge rx_clk) begin
    if (cnt < 0) begin
      if (rx_data === 1'b1) cnt = 0;
    end else begin
      sh = {rx_data, sh[8:1]};
      cnt++;
      if (cnt == 9) begin
        q.push_back({sh[0], sh[8:1]});
        cnt = -1;
      end
    end
  end
endmodule

module clcu_ctrl_model (
  output logic      link_clk,
  output logic      link_data,
  input  wire logic rx_clk,
  input  wire logic rx_data
);
  clcu_tok_mon clcu_tok_mon_i (.rx_clk(rx_clk), .rx_data(rx_data));
  initial begin
    link_clk = 1'b0;
    link_data = 1'b0;
  end
  // data moves only while the clock is low, so each rise sees a settled bit
  task automatic send_tok(input logic [8:0] t);
    logic [9:0] f;
    f = {t[7:0], t[8], 1'b1};
    for (int i = 0; i < 10; i++) begin
      link_data = f[i];
      #80;
      link_clk = 1'b1;
      #80;
      link_clk = 1'b0;
    end
    link_data = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/clcu_top_tb.sv */
// Purpose: self-checking bench of the control link command unit
// Assumes: config space answers two cycles after each request
// Notes: address 16'hffff is the one unmapped config address
`timescale 1ns/1ps
`default_nettype none
`include "clcu_consts.svh"
module clcu_top_tb;
  logic        ref_clk = 1'b0, srst = 1'b1, ce = 1'b1, chain_active = 1'b0;
  logic        cfg_ack = 1'b0, cfg_bad_addr = 1'b0, link_err = 1'b0;
  logic [15:0] device_type = 16'hBEEF;
  logic [31:0] cfg_rdata = 32'h0000_0000;
  logic [7:0]  link_err_code = 8'h00, link_err_num = 8'h00;
  logic        pri_rx_clk, pri_rx_data, pri_tx_clk, pri_tx_data;
  logic        chain_tx_clk, chain_tx_data, cfg_rd_req, cfg_wr_req, reset_req;
  logic [15:0] cfg_addr, seen_addr;
  logic [31:0] cfg_wdata, seen_wdata;
  logic [7:0]  reset_level, rh0 = 8'h00, rh1 = 8'h00;
  int          failures = 0, num_checks = 0, rst_pulses = 0;

  clcu_top clcu_top_i (.ref_clk(ref_clk), .srst(srst), .ce(ce),
    .pri_rx_clk(pri_rx_clk), .pri_rx_data(pri_rx_data),
    .pri_tx_clk(pri_tx_clk), .pri_tx_data(pri_tx_data),
    .chain_active(chain_active), .chain_tx_clk(chain_tx_clk),
    .chain_tx_data(chain_tx_data), .device_type(device_type),
    .cfg_rd_req(cfg_rd_req), .cfg_wr_req(cfg_wr_req), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
    .cfg_bad_addr(cfg_bad_addr), .link_err(link_err),
    .link_err_code(link_err_code), .link_err_num(link_err_num),
    .reset_req(reset_req), .reset_level(reset_level));
  clcu_ctrl_model clcu_ctrl_model_i (.link_clk(pri_rx_clk),
    .link_data(pri_rx_data), .rx_clk(pri_tx_clk), .rx_data(pri_tx_data));
  clcu_tok_mon clcu_tok_mon_i (.rx_clk(chain_tx_clk),
    .rx_data(chain_tx_data));

  always #10 ref_clk = ~ref_clk;

  // config space stand-in; requests are far apart, so blocking here is safe
  always @(posedge ref_clk) begin
    if (reset_req === 1'b1) rst_pulses++;
    if (cfg_rd_req === 1'b1 || cfg_wr_req === 1'b1) begin
      seen_addr = cfg_addr;
      seen_wdata = cfg_wdata;
      repeat (2) @(posedge ref_clk);
      #1 cfg_ack = 1'b1;
      cfg_bad_addr = (seen_addr == 16'hFFFF);
      cfg_rdata = 32'hDDCC_BBAA;
      @(posedge ref_clk);
      #1 cfg_ack = 1'b0;
    end
  end

  task tally_and_finish;
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task check(input string what, input logic [31:0] seen, input logic [31:0] e);
    num_checks++;
    if (seen !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, e, seen);
    end
  endtask

  // next token of the primary (chn 0) or chain (chn 1) output
  task automatic exp(input bit chn, input logic [8:0] e);
    logic [8:0] t;
    pop(chn, t);
    check("token", {23'h0, t}, {23'h0, e});
  endtask

  task automatic pop(input bit chn, output logic [8:0] t);
    int n;
    n = 0;
    while ((chn ? clcu_tok_mon_i.q.size()
                : clcu_ctrl_model_i.clcu_tok_mon_i.q.size()) == 0) begin
      @(posedge ref_clk);
      n++;
      if (n > 600) begin
        failures++;
        tally_and_finish;
      end
    end
    t = chn ? clcu_tok_mon_i.q.pop_front()
            : clcu_ctrl_model_i.clcu_tok_mon_i.q.pop_front();
  endtask

  task automatic cmd(input logic [7:0] h0, h1, input logic [7:0] b[$]);
    clcu_ctrl_model_i.send_tok({1'b0, h0});
    clcu_ctrl_model_i.send_tok({1'b0, h1});
    foreach (b[i]) clcu_ctrl_model_i.send_tok({1'b0, b[i]});
    clcu_ctrl_model_i.send_tok({1'b1, `CLCU_TOK_EOP});
  endtask

  task automatic ack;
    exp(0, {1'b0, rh0});
    exp(0, {1'b0, rh1});
    exp(0, {1'b1, `CLCU_TOK_EOP});
  endtask

  task automatic reply(input logic [7:0] b[$]);
    exp(0, {1'b0, rh0});
    exp(0, {1'b0, rh1});
    foreach (b[i]) exp(0, {1'b0, b[i]});
    exp(0, {1'b1, `CLCU_TOK_EOM});
  endtask

  task t_start_after_err;
    @(posedge ref_clk);
    #1 link_err = 1'b1;
    link_err_code = 8'h33;
    link_err_num = 8'h05;
    @(posedge ref_clk);
    #1 link_err = 1'b0;
    cmd(8'h12, 8'h34, '{`CLCU_CMD_START, 8'hA5, 8'h5A});
    ack();
    rh0 = 8'hA5;
    rh1 = 8'h5A;
    reply('{`CLCU_CMD_START ^ `CLCU_RESP_FLIP, `CLCU_ST_OK});
    reply('{8'h33, 8'h05});
    cmd(8'h12, 8'h34, '{`CLCU_CMD_ERRACK});
    ack();
    reply('{`CLCU_CMD_ERRACK ^ `CLCU_RESP_FLIP, `CLCU_ST_OK});
  endtask

  task t_restart;
    cmd(8'h12, 8'h34, '{`CLCU_CMD_START, 8'h11, 8'h22});
    ack();
    rh0 = 8'h11;
    rh1 = 8'h22;
    reply('{`CLCU_CMD_START ^ `CLCU_RESP_FLIP, `CLCU_ST_OK});
  endtask

  task t_identify;
    cmd(8'h12, 8'h34, '{`CLCU_CMD_IDENT});
    ack();
    reply('{8'h82, device_type[7:0], device_type[15:8], 8'h00, 8'h00});
  endtask

  task t_config;
    cmd(8'h12, 8'h34, '{`CLCU_CMD_PEEK, 8'h10, 8'h02});
    ack();
    reply('{8'h84, `CLCU_ST_OK, 8'hAA, 8'hBB, 8'hCC, 8'hDD});
    check("cfg_addr", {16'h0, seen_addr}, 32'h0000_0210);
    cmd(8'h12, 8'h34, '{`CLCU_CMD_POKE, 8'h20, 8'h00,
                        8'h11, 8'h22, 8'h33, 8'h44});
    ack();
    reply('{8'h85, `CLCU_ST_OK});
    check("cfg_wdata", seen_wdata, 32'h4433_2211);
    cmd(8'h12, 8'h34, '{`CLCU_CMD_POKE, 8'hFF, 8'hFF,
                        8'h01, 8'h02, 8'h03, 8'h04});
    ack();
    reply('{8'h85, `CLCU_ST_FAIL});
    cmd(8'h12, 8'h34, '{`CLCU_CMD_PEEK, 8'hFF, 8'hFF});
    ack();
    reply('{8'h84, `CLCU_ST_FAIL, 8'hAA, 8'hBB, 8'hCC, 8'hDD});
  endtask

  task t_codes;
    cmd(8'h12, 8'h34, '{`CLCU_CMD_RECOVER});
    ack();
    reply('{8'h83, `CLCU_ST_OK});
    cmd(8'h12, 8'h34, '{8'h07});
    ack();
    reply('{8'h87, `CLCU_ST_FAIL});
  endtask

  // recovery overtakes an identify reply that is still going out
  task t_preempt;
    logic [8:0] t;
    logic [8:0] full[10];
    int         i;
    full = '{{1'b0, rh0}, {1'b0, rh1}, {1'b1, `CLCU_TOK_EOP}, {1'b0, rh0},
             {1'b0, rh1}, 9'h082, {1'b0, device_type[7:0]},
             {1'b0, device_type[15:8]}, 9'h000, 9'h000};
    i = 0;
    cmd(8'h12, 8'h34, '{`CLCU_CMD_IDENT});
    cmd(8'h12, 8'h34, '{`CLCU_CMD_RECOVER});
    pop(0, t);
    while (t !== {1'b1, `CLCU_TOK_EOM} && i < 10) begin
      check("cut reply", {23'h0, t}, {23'h0, full[i]});
      i++;
      pop(0, t);
    end
    check("cut point", i > 0 && i < 10, 1);
    ack();
    reply('{8'h83, `CLCU_ST_OK});
  endtask

  task t_chain;
    @(posedge ref_clk);
    #1 chain_active = 1'b1;
    repeat (5) @(posedge ref_clk);
    cmd(8'h77, 8'h88, '{`CLCU_CMD_IDENT});
    exp(1, 9'h077);
    exp(1, 9'h088);
    exp(1, {1'b0, `CLCU_CMD_IDENT});
    exp(1, {1'b1, `CLCU_TOK_EOP});
    #1 chain_active = 1'b0;
    repeat (5) @(posedge ref_clk);
    cmd(8'h77, 8'h88, '{`CLCU_CMD_IDENT});
    reply('{`CLCU_ERR_PROTO, `CLCU_CTRL_LINK});
    cmd(8'h12, 8'h34, '{`CLCU_CMD_ERRACK});
    ack();
    reply('{8'h86, `CLCU_ST_OK});
  endtask

  task t_reset;
    cmd(8'h12, 8'h34, '{`CLCU_CMD_RESET, `CLCU_RST_LVL_MAX + 8'h01});
    ack();
    reply('{8'h81, `CLCU_ST_FAIL});
    check("reset_pulses", rst_pulses, 0);
    cmd(8'h12, 8'h34, '{`CLCU_CMD_RESET, `CLCU_RST_LVL_MAX});
    ack();
    reply('{8'h81, `CLCU_ST_OK});
    check("reset_pulses", rst_pulses, 1);
    check("reset_level", {24'h0, reset_level}, 32'h0000_0002);
  endtask

  // each command but the identify in t_preempt waits for its reply, or for its forwarded tokens in t_chain, before the next one goes out
  initial begin
    repeat (20) @(posedge ref_clk);
    #1 srst = 1'b0;
    repeat (5) @(posedge ref_clk);
    t_start_after_err;
    t_restart;
    t_identify;
    t_config;
    t_codes;
    t_preempt;
    t_chain;
    t_reset;
    tally_and_finish;
  end
endmodule
`default_nettype wire
